//--- design/azx_pkg.sv
// Purpose: Constants and types for the accumulator round-load / XOR unit.
// Assumes: One 50 MHz clock, synchronous active-low reset.
// Notes:   Wait-state counts come from the memory system as inputs.
package azx_pkg;
  localparam int          ACC_W        = 32;
  localparam int          WORD_W       = 16;
  localparam int          SHORT_W      = 8;
  localparam int          SHIFT_W      = 5;
  localparam int          WAIT_W       = 8;
  localparam int          CNT_W        = 16;
  localparam int          AR_W         = 16;
  localparam logic [15:0] ROUND_LOW    = 16'h8000;
  localparam logic [4:0]  SHIFT_MAX_1  = 5'h10;
  localparam logic [4:0]  SHIFT_MAX_2  = 5'h0F;
  localparam logic [7:0]  ONE_CYC      = 8'h01;

  typedef enum logic [1:0] {
    AZX_OP_ROUND_LOAD,
    AZX_OP_XOR_MEM,
    AZX_OP_XOR_LONG
  } azx_op_t;

  // Indirect update options; codes follow the 3-bit update field.
  typedef enum logic [2:0] {
    AZX_IND_NONE    = 3'h0,
    AZX_IND_DEC     = 3'h1,
    AZX_IND_INC     = 3'h2,
    AZX_IND_SUB_IDX = 3'h4,
    AZX_IND_SUB_BR  = 3'h5,
    AZX_IND_ADD_IDX = 3'h6,
    AZX_IND_ADD_BR  = 3'h7
  } azx_ind_t;

  // Bit reversal used for the bit-reversed add or subtract of the index to the pointer.
  function automatic logic [15:0] azx_bitrev(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      azx_bitrev[i] = v[15-i];
    end
  endfunction
endpackage

//--- design/azx_unit.sv
// Purpose: Round-load and XOR accumulator datapath with cycle timing.
// Assumes: Memory operand and wait counts are valid with start.
// Notes:   Busy is high for one cycle less than the cycle count of each form; one-cycle forms raise only done.
`timescale 1ns/100ps
module azx_unit (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  // Instruction request
  input  wire logic                    start,
  input  wire azx_pkg::azx_op_t        op,
  input  wire logic                    indirect,
  input  wire azx_pkg::azx_ind_t       ind_mode,
  input  wire logic [azx_pkg::CNT_W-1:0] repeat_count,
  input  wire logic [azx_pkg::WORD_W-1:0] mem_word,
  input  wire logic [azx_pkg::WORD_W-1:0] long_immediate,
  input  wire logic [azx_pkg::SHIFT_W-1:0] shift_cnt,
  // Memory placement and waits
  input  wire logic                    code_ext,
  input  wire logic                    data_ext,
  input  wire logic                    same_sa_block,
  input  wire logic [azx_pkg::WAIT_W-1:0] p_wait,
  input  wire logic [azx_pkg::WAIT_W-1:0] d_wait,
  input  wire logic [azx_pkg::AR_W-1:0] index_reg,
  // Status
  output logic                         busy,
  output logic                         done,
  output logic                         shift_err,
  output logic [azx_pkg::ACC_W-1:0]    accumulator_reg,
  output logic                         carry,
  output logic [azx_pkg::AR_W-1:0]     aux_register,
  output logic [azx_pkg::CNT_W-1:0]    repeat_counter_reg
);
  import azx_pkg::*;

  // ---------------------------------------------------------------
  // Cycle budget
  // ---------------------------------------------------------------
  localparam int TOT_W = 32;
  logic [TOT_W-1:0] total;
  logic [TOT_W-1:0] n;
  logic [TOT_W-1:0] p;
  logic [TOT_W-1:0] d;
  logic             shift_bad;

  always_comb begin
    n = {16'h0000, repeat_count} + 32'h1;
    p = {24'h000000, p_wait};
    d = {24'h000000, d_wait};
    total = n;
    if (op == AZX_OP_XOR_LONG) begin
      total = code_ext ? 32'h2 + (p << 1) : 32'h2;
    end else if (code_ext && data_ext) begin
      total = n + 32'h1 + p + n * d;
    end else if (data_ext) begin
      total = n + n * d;
    end else if (code_ext) begin
      total = n + p;
    end else if (same_sa_block) begin
      total = n + 32'h1;
    end
    shift_bad = (op == AZX_OP_XOR_LONG) ?
                (shift_cnt > SHIFT_MAX_1) : 1'b0;
  end

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  logic [TOT_W-1:0] left_r;
  logic             busy_r;
  logic             done_r;
  azx_op_t          op_r;
  logic             ind_r;
  azx_ind_t         mode_r;
  logic [WORD_W-1:0] opnd_r;
  logic [SHIFT_W-1:0] sh_r;

  assign busy = busy_r;
  assign done = done_r;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      left_r <= '0;
      op_r   <= AZX_OP_ROUND_LOAD;
      ind_r  <= 1'b0;
      mode_r <= AZX_IND_NONE;
      opnd_r <= '0;
      sh_r   <= '0;
      shift_err <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && start) begin
        shift_err <= shift_bad;
        if (!shift_bad) begin
          busy_r <= (total != 32'h1);
          done_r <= (total == 32'h1);
          left_r <= total - 32'h1;
          op_r   <= op;
          ind_r  <= indirect;
          mode_r <= ind_mode;
          opnd_r <= (op == AZX_OP_XOR_LONG) ? long_immediate : mem_word;
          sh_r   <= shift_cnt;
        end
      end else if (busy_r) begin
        left_r <= left_r - 32'h1;
        if (left_r == 32'h1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Accumulator datapath
  // ---------------------------------------------------------------
  logic [ACC_W-1:0] imm_shifted;
  assign imm_shifted = ACC_W'({16'h0000, long_immediate} << shift_cnt);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      accumulator_reg <= '0;
      carry           <= 1'b0;
    end else if (!busy_r && start && !shift_bad) begin
      unique case (op)
        AZX_OP_ROUND_LOAD:
          accumulator_reg <= {mem_word, ROUND_LOW};
        AZX_OP_XOR_MEM:
          accumulator_reg <= {accumulator_reg[31:16],
                              accumulator_reg[15:0] ^ mem_word};
        AZX_OP_XOR_LONG:
          accumulator_reg <= accumulator_reg ^ imm_shifted;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pointer and repeat counter
  // ---------------------------------------------------------------
  function automatic logic [AR_W-1:0] ar_upd(input logic [AR_W-1:0] a,
                                             input azx_ind_t m,
                                             input logic [AR_W-1:0] x);
    unique case (m)
      AZX_IND_NONE:    ar_upd = a;
      AZX_IND_INC:     ar_upd = a + 16'h0001;
      AZX_IND_DEC:     ar_upd = a - 16'h0001;
      AZX_IND_ADD_IDX: ar_upd = a + x;
      AZX_IND_SUB_IDX: ar_upd = a - x;
      AZX_IND_ADD_BR:  ar_upd = azx_bitrev(azx_bitrev(a) + azx_bitrev(x));
      AZX_IND_SUB_BR:  ar_upd = azx_bitrev(azx_bitrev(a) - azx_bitrev(x));
      default:         ar_upd = a;
    endcase
  endfunction

  logic first_pass;
  assign first_pass = !busy_r && start && !shift_bad;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      aux_register       <= '0;
      repeat_counter_reg <= '0;
    end else if (first_pass) begin
      repeat_counter_reg <= repeat_count;
      if (indirect && op != AZX_OP_XOR_LONG) begin
        aux_register <= ar_upd(aux_register, ind_mode, index_reg);
      end
    end else if (busy_r && repeat_counter_reg != '0) begin
      repeat_counter_reg <= repeat_counter_reg - 16'h0001;
      if (ind_r && op_r != AZX_OP_XOR_LONG) begin
        aux_register <= ar_upd(aux_register, mode_r, index_reg);
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_ROUND_LOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op == AZX_OP_ROUND_LOAD |=>
    accumulator_reg[15:0] == ROUND_LOW)
    else $error("round load low half wrong");
  AST_ROUND_HIGH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op == AZX_OP_ROUND_LOAD |=>
    accumulator_reg[31:16] == $past(mem_word))
    else $error("round load high half wrong");
  AST_XOR_HIGH_KEPT: assert property (@(posedge clk_sys)
    disable iff (!reset_n) first_pass && op == AZX_OP_XOR_MEM |=>
    $stable(accumulator_reg[31:16]) && $stable(carry))
    else $error("memory xor changed upper half");
  AST_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op != AZX_OP_XOR_LONG && repeat_count == 16'h0000 &&
    !code_ext && !data_ext && !same_sa_block |=> done && !busy)
    else $error("on-chip single not one cycle");
  AST_SAME_BLOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op != AZX_OP_XOR_LONG && repeat_count == 16'h0000 &&
    !code_ext && !data_ext && same_sa_block |=> busy ##1 done)
    else $error("same block not two cycles");
  AST_LONG_TWO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op == AZX_OP_XOR_LONG && !code_ext |=>
    !done ##1 done)
    else $error("long xor not two cycles");
  AST_SHIFT_RANGE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !busy && start && op == AZX_OP_XOR_LONG && shift_cnt > SHIFT_MAX_1 |=>
    shift_err && !busy)
    else $error("bad shift accepted");
  AST_RPT_COUNT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    busy && repeat_counter_reg != 16'h0000 |=>
    repeat_counter_reg == $past(repeat_counter_reg) - 16'h0001)
    else $error("repeat counter not counting");
  AST_EXT_BOTH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op != AZX_OP_XOR_LONG && repeat_count == 16'h0000 &&
    code_ext && data_ext |=>
    busy && left_r == $past({24'h000000, d_wait}) +
                      $past({24'h000000, p_wait}) + 32'h1)
    else $error("both external not 2+d+p");

  // ---------------------------------------------------------------
  // Timing checks on the loaded cycle budget
  // ---------------------------------------------------------------
  // The remaining count after acceptance is the total minus one, so
  // each form can be checked at the taking edge rather than at done.
  AST_DATA_EXT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op != AZX_OP_XOR_LONG && repeat_count == 16'h0000 &&
    data_ext && !code_ext |=>
    left_r == $past({24'h000000, d_wait}))
    else $error("external operand not 1+d");
  AST_CODE_EXT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op != AZX_OP_XOR_LONG && repeat_count == 16'h0000 &&
    code_ext && !data_ext |=>
    left_r == $past({24'h000000, p_wait}))
    else $error("external code not 1+p");
  AST_LONG_EXT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op == AZX_OP_XOR_LONG && code_ext |=>
    left_r == $past({23'h000000, p_wait, 1'b0}) + 32'h1)
    else $error("external long xor not 2+2p");
  AST_RPT_ONCHIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op != AZX_OP_XOR_LONG && !code_ext && !data_ext &&
    !same_sa_block |=>
    left_r == $past({16'h0000, repeat_count}))
    else $error("on-chip repeat not n cycles");
  AST_BUSY_ENDS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    busy && left_r == 32'h1 |=> !busy && done)
    else $error("busy did not end with done");
  // A new request may be taken while done is high, so the pulse check
  // only applies when no start is waiting in that cycle.
  AST_DONE_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    done && !start |=> !done)
    else $error("done longer than one cycle");

  // ---------------------------------------------------------------
  // Datapath checks
  // ---------------------------------------------------------------
  AST_XOR_MEM_LOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op == AZX_OP_XOR_MEM |=>
    accumulator_reg[15:0] ==
      $past(accumulator_reg[15:0] ^ mem_word))
    else $error("memory xor low half wrong");
  AST_XOR_LONG_VAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && op == AZX_OP_XOR_LONG |=>
    accumulator_reg == $past(accumulator_reg ^
      ({16'h0000, long_immediate} << shift_cnt)))
    else $error("long xor result wrong");
  AST_CARRY_KEPT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !carry)
    else $error("carry changed");
  // Results land at acceptance; the busy time is only the bus cost.
  AST_ACC_HELD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    busy |=> $stable(accumulator_reg))
    else $error("accumulator moved while busy");
  AST_AR_DIRECT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass && !indirect |=> $stable(aux_register))
    else $error("pointer moved on direct operand");
  AST_RPT_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pass |=> repeat_counter_reg == $past(repeat_count))
    else $error("repeat counter not loaded");
  AST_SHIFT_OK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !busy && start && op == AZX_OP_XOR_LONG &&
    shift_cnt <= SHIFT_MAX_1 |=> !shift_err)
    else $error("legal shift refused");
endmodule

//--- sim/azx_mem_model.sv
// Purpose: Data memory as seen through the auxiliary pointer.
// Assumes: Reads are combinational; waits are set by the bench.
// Notes:   Contents are a fixed pattern so every word is predictable.
`timescale 1ns/100ps
module azx_mem_model (
  // Address
  input  wire logic [15:0] addr,
  // Read data
  output logic      [15:0] rd_data
);
  // A pattern needs no storage and keeps neighbouring words distinct.
  assign rd_data = addr ^ 16'hA5C3;
endmodule

//--- sim/acc_round_load_xor_timing_test.sv
// Purpose: Self-checking bench for the round-load and XOR unit.
// Assumes: Waits are p=3 and d=2 throughout; index is 13h.
// Notes:   Repeated forms are checked on timing and pointer only, plus the repeat counter in the round-load test.
`timescale 1ns/100ps
module acc_round_load_xor_timing_test;
  import azx_pkg::*;
  logic        clk_sys = 1'b0, reset_n, start, indirect, busy, done;
  logic        code_ext, data_ext, same_sa_block, shift_err, carry;
  azx_op_t     op;
  azx_ind_t    ind_mode;
  logic [15:0] repeat_count, mem_word, long_immediate, index_reg;
  logic [15:0] aux_register, repeat_counter_reg, exp_ar;
  logic [4:0]  shift_cnt;
  logic [7:0]  p_wait, d_wait;
  logic [31:0] accumulator_reg, exp_acc;
  int          bad_count, checks_done;

  always #10 clk_sys = ~clk_sys;

  azx_unit azx_unit_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .start(start), .op(op),
    .indirect(indirect), .ind_mode(ind_mode), .repeat_count(repeat_count),
    .mem_word(mem_word), .long_immediate(long_immediate),
    .shift_cnt(shift_cnt), .code_ext(code_ext), .data_ext(data_ext),
    .same_sa_block(same_sa_block), .p_wait(p_wait), .d_wait(d_wait),
    .index_reg(index_reg), .busy(busy), .done(done),
    .shift_err(shift_err), .accumulator_reg(accumulator_reg),
    .carry(carry), .aux_register(aux_register),
    .repeat_counter_reg(repeat_counter_reg));
  azx_mem_model azx_mem_model_i (.addr(aux_register), .rd_data(mem_word));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d bad=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [15:0] rv(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rv[i] = v[15-i];
  endfunction

  // Reverse-carry arithmetic is modelled by reversing around a plain add or subtract.
  function automatic logic [15:0] nxt(input logic [15:0] a, azx_ind_t m);
    case (m)
      AZX_IND_DEC:     return a - 16'h1;
      AZX_IND_INC:     return a + 16'h1;
      AZX_IND_SUB_IDX: return a - 16'h13;
      AZX_IND_ADD_IDX: return a + 16'h13;
      AZX_IND_SUB_BR:  return rv(rv(a) - rv(16'h13));
      AZX_IND_ADD_BR:  return rv(rv(a) + rv(16'h13));
      default:         return a;
    endcase
  endfunction

  task automatic go(input azx_op_t o, azx_ind_t m, logic ind,
      logic [15:0] rc, logic [2:0] pl, logic [4:0] s, int et);
    int t;
    @(posedge clk_sys);
    start <= 1'b1;
    op <= o;
    ind_mode <= m;
    indirect <= ind;
    repeat_count <= rc;
    shift_cnt <= s;
    {code_ext, data_ext, same_sa_block} <= pl;
    @(posedge clk_sys);
    start <= 1'b0;
    t = 0;
    @(negedge clk_sys);
    if (et > 1) chk(busy, 1'b1);
    while (done !== 1'b1 && t < 300) begin
      @(negedge clk_sys);
      t++;
    end
    if (t >= 300) begin
      bad_count++;
      wrap_up();
    end
    chk(t + 1, et);
    for (int i = 0; ind && i <= rc; i++) exp_ar = nxt(exp_ar, m);
  endtask

  task automatic seed(input logic [2:0] pl, int et);
    exp_acc = {exp_ar ^ 16'hA5C3, 16'h0000} + 32'h0000_8000;
    go(AZX_OP_ROUND_LOAD, AZX_IND_NONE, 1'b0, 16'h0, pl, 5'h0, et);
    chk(accumulator_reg, exp_acc);
  endtask

  logic [2:0] pl [5] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1};
  int         et1 [5] = '{1, 4, 3, 7, 2};
  azx_ind_t   md [7] = '{AZX_IND_NONE, AZX_IND_DEC, AZX_IND_INC,
      AZX_IND_SUB_IDX, AZX_IND_SUB_BR, AZX_IND_ADD_IDX, AZX_IND_ADD_BR};

  task automatic t_round();
    int etn [5] = '{4, 7, 12, 16, 5};
    for (int i = 0; i < 5; i++) begin
      seed(pl[i], et1[i]);
      go(AZX_OP_ROUND_LOAD, AZX_IND_INC, 1'b1, 16'h3, pl[i], 5'h0, etn[i]);
      chk(aux_register, exp_ar);
      chk(repeat_counter_reg, 32'h0);
    end
    $display("round load test finished");
  endtask

  task automatic t_xor();
    int etn [5] = '{3, 6, 9, 13, 4};
    seed(3'h0, 1);
    for (int i = 0; i < 5; i++) begin
      exp_acc[15:0] = exp_acc[15:0] ^ exp_ar ^ 16'hA5C3;
      go(AZX_OP_XOR_MEM, AZX_IND_NONE, 1'b0, 16'h0, pl[i], 5'h0, et1[i]);
      chk(accumulator_reg, exp_acc);
      chk(carry, 1'b0);
    end
    for (int i = 0; i < 7; i++) begin
      go(AZX_OP_XOR_MEM, md[i], 1'b1, 16'h2, pl[i%5], 5'h0, etn[i%5]);
      chk(aux_register, exp_ar);
    end
    $display("memory xor test finished");
  endtask

  task automatic t_long();
    logic [4:0] sh [3] = '{5'h00, 5'h0F, 5'h10};
    seed(3'h0, 1);
    long_immediate <= 16'hC3A5;
    for (int i = 0; i < 3; i++) begin
      exp_acc = exp_acc ^ ({16'h0000, 16'hC3A5} << sh[i]);
      go(AZX_OP_XOR_LONG, AZX_IND_NONE, 1'b0, 16'h0, (i == 2) ? 3'h6 : 3'h0,
         sh[i], (i == 2) ? 8 : 2);
      chk(accumulator_reg, exp_acc);
      chk(shift_err, 1'b0);
    end
    @(posedge clk_sys);
    start <= 1'b1;
    shift_cnt <= 5'h11;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(shift_err, 1'b1);
    chk(accumulator_reg, exp_acc);
    chk(busy, 1'b0);
    $display("long xor test finished");
  endtask

  initial begin
    {reset_n, start, indirect, code_ext, data_ext, same_sa_block} = '0;
    op = AZX_OP_ROUND_LOAD;
    ind_mode = AZX_IND_NONE;
    {repeat_count, long_immediate, exp_ar, exp_acc} = '0;
    shift_cnt = 5'h00;
    p_wait = 8'h03;
    d_wait = 8'h02;
    index_reg = 16'h0013;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk(accumulator_reg, 32'h0);
    t_round();
    t_xor();
    t_long();
    wrap_up();
  end
endmodule
